// >>> hdl/byte_dp_pkg.sv
// Purpose: constants for the byte move/increment/or datapath
// Assumes: one instruction issued per enabled clock, decoded outside
// Notes: opcode codes below are local encodings of the decoded instruction
// Functional notes
// - increment_file adds one, routes, updates zero
// - target bit 0 writes accumulator for increment/or/copy, register kept
// - target bit 1 writes register for increment/or/copy, accumulator kept
// - or_accumulator_into_file ORs, routes, updates zero
// - register address is seven bits, 0..127
// - copy_file moves register to chosen destination
// - copy_file updates zero; one word, one cycle
// - store_accumulator writes register, flags unchanged
// - load_literal loads 8-bit literal, flags unchanged
package byte_dp_pkg;
  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 7;
  localparam int          NUM_REGS    = 128;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam logic        ZERO_RST    = 1'b0;
  localparam logic [7:0]  INC_STEP    = 8'h01;
  localparam int          EXEC_CYCLES = 1;

  // ---------------------------------------------------------------
  // operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE          = 3'b000,
    OP_INCREMENT     = 3'b001,
    OP_OR_ACC        = 3'b010,
    OP_COPY          = 3'b011,
    OP_STORE_ACC     = 3'b100,
    OP_LOAD_LITERAL  = 3'b101
  } op_e;
endpackage : byte_dp_pkg

// >>> hdl/byte_dp_alu.sv
// Purpose: combinational result and zero detection
// Assumes: operands valid in the issue cycle
// Notes: pure logic, no state
`timescale 1ns/1ps
module byte_dp_alu
  import byte_dp_pkg::*;
(
  input  wire byte_dp_pkg::op_e                i_op,
  input  wire logic [byte_dp_pkg::DATA_W-1:0]  i_acc,
  input  wire logic [byte_dp_pkg::DATA_W-1:0]  i_reg,
  input  wire logic [byte_dp_pkg::DATA_W-1:0]  i_lit,
  output logic      [byte_dp_pkg::DATA_W-1:0]  o_result,
  output logic                                 o_zero,
  output logic                                 o_flag_upd
);
  import byte_dp_pkg::*;
  // ---------------------------------------------------------------
  // result select
  // ---------------------------------------------------------------
  // increment wraps naturally in eight bits, 0xFF -> 0x00
  wire [DATA_W-1:0] inc_val = i_reg + INC_STEP;
  wire [DATA_W-1:0] or_val  = i_acc | i_reg;

  assign o_result = (i_op == OP_INCREMENT)    ? inc_val :
                    (i_op == OP_OR_ACC)       ? or_val  :
                    (i_op == OP_COPY)         ? i_reg   :
                    (i_op == OP_STORE_ACC)    ? i_acc   :
                    (i_op == OP_LOAD_LITERAL) ? i_lit   :
                    i_acc;
  assign o_zero     = (o_result == '0);
  assign o_flag_upd = (i_op == OP_INCREMENT) || (i_op == OP_OR_ACC) ||
                      (i_op == OP_COPY);
endmodule : byte_dp_alu

// >>> hdl/byte_dp_core.sv
// Purpose: accumulator, register file and zero flag for five byte instructions
// Assumes: decode outside presents one op per enabled cycle
// Notes: every op completes in the cycle it is issued
`timescale 1ns/1ps
module byte_dp_core
  import byte_dp_pkg::*;
#(
  parameter int REGS = NUM_REGS
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  input  wire logic                            i_en,
  input  wire logic                            i_valid,
  input  wire byte_dp_pkg::op_e                i_op,
  input  wire logic [byte_dp_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic                            i_target,
  input  wire logic [byte_dp_pkg::DATA_W-1:0]  i_lit,
  input  wire logic [byte_dp_pkg::ADDR_W-1:0]  i_rd_addr,
  output logic      [byte_dp_pkg::DATA_W-1:0]  o_acc,
  output logic                                 o_zero,
  output logic      [byte_dp_pkg::DATA_W-1:0]  o_rd_data
);
  import byte_dp_pkg::*;

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (REGS < 1 || REGS > (1 << ADDR_W)) begin : g_bad_regs
    $error("REGS must fit the seven-bit address");
  end
  if (EXEC_CYCLES != 1) begin : g_bad_cycles
    $error("every op must retire in the cycle it is issued");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] acc_ff;
  logic              zero_ff;
  logic [DATA_W-1:0] file_ff [REGS];

  wire              go = i_en && i_valid;
  wire [DATA_W-1:0] cur_reg = file_ff[i_addr];
  wire [DATA_W-1:0] result;
  wire              res_zero;
  wire              flag_upd;
  // neighbour entry and read-port peek, watched by the assertions only
  wire [ADDR_W-1:0] nbr_addr = {i_addr[ADDR_W-1:1], ~i_addr[0]};
  wire [DATA_W-1:0] nbr_reg  = file_ff[nbr_addr];
  wire [DATA_W-1:0] rd_peek  = file_ff[i_rd_addr];

  byte_dp_alu u_alu (
    .i_op       (i_op),
    .i_acc      (acc_ff),
    .i_reg      (cur_reg),
    .i_lit      (i_lit),
    .o_result   (result),
    .o_zero     (res_zero),
    .o_flag_upd (flag_upd)
  );

  // ---------------------------------------------------------------
  // destination decode
  // ---------------------------------------------------------------
  wire routed    = (i_op == OP_INCREMENT) || (i_op == OP_OR_ACC) || (i_op == OP_COPY);
  // store ignores the target bit: it always writes the register
  wire wr_file   = go && ((routed && i_target) || (i_op == OP_STORE_ACC));
  wire wr_acc    = go && ((routed && !i_target) ||
                          (i_op == OP_LOAD_LITERAL));
  wire nxt_zero  = (go && flag_upd) ? res_zero : zero_ff;
  wire [DATA_W-1:0] nxt_acc = wr_acc ? result : acc_ff;

  // ---------------------------------------------------------------
  // accumulator and zero flag
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_ff  <= ACC_RST;
      zero_ff <= ZERO_RST;
    end else if (i_en) begin
      acc_ff  <= nxt_acc;
      zero_ff <= nxt_zero;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  // one writer per entry, so a write never disturbs a neighbour
  genvar gi;
  for (gi = 0; gi < REGS; gi++) begin : g_file
    wire hit = wr_file && (i_addr == ADDR_W'(gi));
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        file_ff[gi] <= REG_RST;
      end else if (hit) begin
        file_ff[gi] <= result;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // shows the old value when the same entry is written on that edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= REG_RST;
    end else if (i_en) begin
      o_rd_data <= file_ff[i_rd_addr];
    end
  end

  assign o_acc  = acc_ff;
  assign o_zero = zero_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  inc_wraps_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_INCREMENT && !i_target && cur_reg == 8'hFF
    |=> acc_ff == 8'h00 && zero_ff)
    else $error("increment wrap or zero wrong");
  inc_wrapf_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_INCREMENT && i_target && cur_reg == 8'hFF
    |=> file_ff[$past(i_addr)] == 8'h00 && zero_ff)
    else $error("increment wrap into register wrong");
  inc_acc_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_INCREMENT && !i_target
    |=> acc_ff == DATA_W'($past(cur_reg) + 8'h01))
    else $error("increment to accumulator wrong");
  inc_file_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_INCREMENT && i_target
    |=> file_ff[$past(i_addr)] == DATA_W'($past(cur_reg) + 8'h01) &&
        zero_ff == (DATA_W'($past(cur_reg) + 8'h01) == 8'h00))
    else $error("increment to register wrong");

  dest_reg_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && (i_op == OP_INCREMENT || i_op == OP_OR_ACC) && i_target
    |=> $stable(acc_ff))
    else $error("accumulator changed on register destination");
  dest_acc_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && (i_op == OP_INCREMENT || i_op == OP_OR_ACC) && !i_target
    |=> file_ff[$past(i_addr)] == $past(cur_reg))
    else $error("register changed on accumulator destination");

  or_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_OR_ACC
    |=> zero_ff == (($past(acc_ff) | $past(cur_reg)) == 8'h00))
    else $error("or zero flag wrong");
  or_acc_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_OR_ACC && !i_target
    |=> acc_ff == ($past(acc_ff) | $past(cur_reg)))
    else $error("or into accumulator wrong");
  or_file_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_OR_ACC && i_target
    |=> file_ff[$past(i_addr)] == ($past(acc_ff) | $past(cur_reg)))
    else $error("or into register wrong");

  copy_acc_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_COPY && !i_target
    |=> acc_ff == $past(cur_reg) && zero_ff == ($past(cur_reg) == 8'h00))
    else $error("copy to accumulator wrong");
  copy_file_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_COPY
    |=> file_ff[$past(i_addr)] == $past(cur_reg))
    else $error("copy altered the register");
  copy_test_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_COPY && i_target
    |=> zero_ff == ($past(cur_reg) == 8'h00) && $stable(acc_ff))
    else $error("copy self test wrong");

  store_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_STORE_ACC
    |=> file_ff[$past(i_addr)] == $past(acc_ff) && $stable(zero_ff))
    else $error("store wrong");
  store_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_STORE_ACC
    |=> $stable(acc_ff))
    else $error("store changed the accumulator");
  literal_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_LOAD_LITERAL
    |=> acc_ff == $past(i_lit) && $stable(zero_ff))
    else $error("literal load wrong");
  lit_file_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_LOAD_LITERAL
    |=> file_ff[$past(i_addr)] == $past(cur_reg))
    else $error("literal load changed a register");
  zero_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !(go && flag_upd)
    |=> $stable(zero_ff))
    else $error("zero flag moved without a flag op");

  nbr_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go
    |=> file_ff[$past(nbr_addr)] == $past(nbr_reg))
    else $error("write reached a neighbouring register");
  bad_op_a: assert property (@(posedge i_clk) disable iff (i_rst)
    go && !(i_op inside {OP_INCREMENT, OP_OR_ACC, OP_COPY,
                         OP_STORE_ACC, OP_LOAD_LITERAL})
    |=> $stable(acc_ff) && file_ff[$past(i_addr)] == $past(cur_reg))
    else $error("unknown op changed state");
  idle_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_en && !i_valid
    |=> $stable(acc_ff) && $stable(zero_ff) && file_ff[$past(i_addr)] == $past(cur_reg))
    else $error("state moved without an instruction");
  hold_en_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_en |=> $stable(acc_ff) && $stable(zero_ff) && $stable(o_rd_data) &&
              file_ff[$past(i_addr)] == $past(cur_reg))
    else $error("state moved while disabled");
  rd_port_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_en
    |=> o_rd_data == $past(rd_peek))
    else $error("read port wrong");
  rst_clear_a: assert property (@(posedge i_clk)
    i_rst && $past(i_rst)
    |-> acc_ff == ACC_RST && zero_ff == ZERO_RST && o_rd_data == REG_RST && cur_reg == REG_RST)
    else $error("reset values wrong");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  inc_wrap_c:  cover property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_INCREMENT && cur_reg == 8'hFF);
  or_file_c:   cover property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_OR_ACC && i_target);
  copy_zero_c: cover property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_COPY && i_target && cur_reg == 8'h00);
  store_lit_c: cover property (@(posedge i_clk) disable iff (i_rst)
    go && i_op == OP_LOAD_LITERAL ##1 go && i_op == OP_STORE_ACC);
  dis_hold_c:  cover property (@(posedge i_clk) disable iff (i_rst)
    !i_en && i_valid && i_op == OP_LOAD_LITERAL);
endmodule : byte_dp_core

// >>> test/tb.sv
// Purpose: random self-checking bench for the byte datapath core
// Assumes: results show one edge after issue; read port lags one edge
// Notes: a reference model notes acc, zero and read data per edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
  import byte_dp_pkg::*;
  // ------------------------------------------------------------
  // signals and model
  // ------------------------------------------------------------
  logic              i_clk, i_rst, i_en, i_valid, i_target, o_zero, m_zero;
  op_e               i_op;
  logic [ADDR_W-1:0] i_addr, i_rd_addr, prev_a;
  logic [DATA_W-1:0] i_lit, o_acc, o_rd_data, m_acc, m_rd, res;
  logic [DATA_W-1:0] m_file [NUM_REGS];
  logic [16:0]       q [$];
  logic [16:0]       exp_v;
  logic [31:0]       r;
  int                num_errors, num_checks, cycles;
  int                seed = 31;
  byte_dp_core #(.REGS(NUM_REGS)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_en(i_en),
    .i_valid(i_valid), .i_op(i_op), .i_addr(i_addr), .i_target(i_target), .i_lit(i_lit),
    .i_rd_addr(i_rd_addr), .o_acc(o_acc), .o_zero(o_zero), .o_rd_data(o_rd_data));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic reset_all(input int n);
    i_rst = 1'b1;
    i_valid = 1'b0;
    m_acc = 8'h00;
    m_zero = 1'b0;
    m_rd = 8'h00;
    foreach (m_file[k]) m_file[k] = 8'h00;
    repeat (n) @(negedge i_clk);
    i_rst = 1'b0;
  endtask : reset_all
  task automatic step(input logic en, input logic vl, input op_e op,
                      input logic [ADDR_W-1:0] a, input logic tg, input logic [DATA_W-1:0] lit);
    logic go;
    go = en && vl;
    case (op)
      OP_INCREMENT: res = m_file[a] + INC_STEP;
      OP_OR_ACC:    res = m_file[a] | m_acc;
      OP_COPY:      res = m_file[a];
      OP_STORE_ACC: res = m_acc;
      default:      res = lit;
    endcase
    // read back last target; a same-edge write shows one edge later
    i_rd_addr = prev_a;
    if (en) m_rd = m_file[i_rd_addr];
    if (go && op inside {OP_INCREMENT, OP_OR_ACC, OP_COPY}) begin
      m_zero = (res == 8'h00);
      if (tg) m_file[a] = res;
      else m_acc = res;
    end
    if (go && op == OP_STORE_ACC) m_file[a] = res;
    if (go && op == OP_LOAD_LITERAL) m_acc = res;
    {i_en, i_valid, i_addr, i_target, i_lit} = {en, vl, a, tg, lit};
    i_op = op;
    prev_a = a;
    q.push_back({m_acc, m_zero, m_rd});
    @(negedge i_clk);
  endtask : step
  task automatic summarize;
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {i_en, i_target, i_addr, i_rd_addr, i_lit, prev_a} = '0;
    i_op = OP_NONE;
    reset_all(20);
    step(1'b1, 1'b1, OP_LOAD_LITERAL, 7'h7F, 1'b0, 8'hFF);
    step(1'b1, 1'b1, OP_STORE_ACC, 7'h7F, 1'b0, 8'h00);
    step(1'b1, 1'b1, OP_INCREMENT, 7'h7F, 1'b0, 8'h00);
    step(1'b1, 1'b1, OP_COPY, 7'h7F, 1'b1, 8'h00);
    for (int n = 0; n < 3000; n++) begin
      r = $random(seed);
      // small address set half of the time, so writes and reads collide
      step(r[31:28] != 4'h0, r[27:25] != 3'h0, op_e'(r[2:0]), r[3] ? r[10:4] : 7'(r[5:4]),
           r[11], r[12] ? 8'hFF : (r[21] ? 8'h00 : r[20:13]));
      if (n == 1500) reset_all(3);
    end
    summarize();
  end
  // ------------------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    cycles++;
    #1;
    if (q.size() > 0) begin
      exp_v = q.pop_front();
      `CHK("acc", exp_v[16:9], o_acc)
      `CHK("zero", exp_v[8], o_zero)
      `CHK("rd_data", exp_v[7:0], o_rd_data)
    end
  end
  initial begin
    while (cycles < 20000) @(posedge i_clk);
    num_errors++;
    summarize();
  end
endmodule : tb
